// File: ms_timer.sv
// Purpose: Millisecond one-shot timer, restartable.
// Assumes: MS_CYCLES clock cycles make one millisecond.
// Notes:   Clear wins over start; expired is a one-cycle pulse.
`include "rx_term_consts.svh"

module ms_timer
	import rx_term_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	// Clock and reset.
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Control.
	input  wire logic         clear,
	input  wire logic         start,
	input  wire logic [15:0]  period_ms,
	// Result.
	output logic              expired
);

	logic [31:0]  cyc;
	logic [15:0]  ms;
	logic         armed;

	wire          ms_wrap = (cyc == 32'(MS_CYCLES - 1));
	wire  [16:0]  ms_next = {1'b0, ms} + 17'h00001;
	wire          done    = ms_wrap && (ms_next >= {1'b0, period_ms});

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed   <= 1'b0;
			cyc     <= 32'h0000_0000;
			ms      <= 16'h0000;
			expired <= 1'b0;
		end else begin
			expired <= armed && !clear && !start && done;
			if (clear) begin
				armed <= 1'b0;
			end else if (start) begin
				armed <= 1'b1;
				cyc   <= 32'h0000_0000;
				ms    <= 16'h0000;
			end else if (armed && done) begin
				armed <= 1'b0;
			end else if (armed) begin
				cyc <= ms_wrap ? 32'h0000_0000 : cyc + 32'h0000_0001;
				ms  <= ms_wrap ? ms_next[15:0] : ms;
			end
		end
	end

endmodule

// File: rx_term_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by the terminator package and its modules.
// Notes:   Definitions only.
`ifndef RX_TERM_CONSTS_SVH
`define RX_TERM_CONSTS_SVH

`define AXI_ADDR_W        6
`define ADDR_SELECT       6'h00
`define ADDR_TERM_COUNT   6'h04
`define ADDR_TERM_LO      6'h08
`define ADDR_TERM_HI      6'h0C
`define ADDR_PKT_LEN      6'h10
`define ADDR_MSG_MS       6'h14
`define ADDR_GAP_MS       6'h18
`define ADDR_HANDSHAKE    6'h1C
`define ADDR_STATUS       6'h20
`define ADDR_LEVELS       6'h24
`define NUM_CFG_REGS      8

`define SEL_TERM_BIT      0
`define SEL_MSG_BIT       1
`define SEL_GAP_BIT       2
`define SEL_LEN_BIT       3

`define MASK_SELECT       32'h0000_00FF
`define MASK_TERM_COUNT   32'h0000_0007
`define MASK_TERM_LO      32'hFFFF_FFFF
`define MASK_TERM_HI      32'h0000_FFFF
`define MASK_PKT_LEN      32'h0000_1FFF
`define MASK_MS           32'h0000_FFFF
`define MASK_HANDSHAKE    32'h0000_0001

`define RESET_MSG_MS      32'h0000_03E8
`define RESET_GAP_MS      32'h0000_012C
`define RESET_ZERO        32'h0000_0000

`define TERM_SLOTS        6
`define BUF_DEPTH         4096
`define PAGE_MAX          240
`define RTS_MARGIN        16

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define CLK_PERIOD_NS     5
`define MS_IN_NS          1000000
`define MS_CYCLES         (`MS_IN_NS / `CLK_PERIOD_NS)

`endif

// File: rx_term_monitor.sv
// Purpose: Port checker for the receive terminator.
// Assumes: Writes offer address and data together.
// Notes:   Bound to the design from the testbench.
`include "rx_term_consts.svh"

module rx_term_monitor
	import rx_term_pkg::*;
(
	// Clock, reset and register bus.
	input wire logic aclk, aresetn, awvalid, awready, wvalid, wready,
	input wire logic bvalid, bready, arvalid, arready, rvalid, rready,
	input wire logic [`AXI_ADDR_W-1:0] awaddr, araddr,
	input wire logic [31:0] wdata, rdata,
	input wire logic [1:0] rresp,
	// Character, host and modem ports.
	input wire logic rx_valid, rx_ready, host_valid, host_ready, rts_out,
	input wire logic [7:0] rx_char,
	input wire host_byte_s host_byte
);
	logic [7:0] sel;
	logic       hs;
	wire        wr_go = awvalid && awready && wvalid && wready;
	wire        rx_go = rx_valid && rx_ready;
	wire        rd_go = arvalid && arready;

	// Shadow of the selector and handshake settings.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel <= 8'h00;
			hs <= 1'b0;
		end else if (wr_go) begin
			if (awaddr == `ADDR_SELECT) sel <= wdata[7:0];
			if (awaddr == `ADDR_HANDSHAKE) hs <= wdata[0];
		end
	end

	////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	host_hold_a: assert property (
		host_valid && !host_ready |=> host_valid && $stable(host_byte))
		else $error("host byte changed while stalled");
	stream_fwd_a: assert property (
		sel[3:0] == 4'h0 && rx_go && !host_valid && !$past(rx_go) |=> ##1
		host_valid && host_byte.last && host_byte.data == $past(rx_char, 2))
		else $error("stream character not forwarded alone");
	rd_ans_a: assert property (rd_go |=> rvalid && !arready)
		else $error("read answer late");
	rd_err_a: assert property (
		rd_go && (araddr > `ADDR_LEVELS || araddr[1:0] != 2'b00) |=>
		rresp == `RESP_SLVERR && rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	sel_res_a: assert property (
		rd_go && araddr == `ADDR_SELECT |=> rdata[31:8] == 24'h00_0000)
		else $error("selector upper bits not zero");
	wr_ans_a: assert property (wr_go |=> !awready ##1 bvalid)
		else $error("write answer not two edges later");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data changed while stalled");
	rts_off_a: assert property (
		!hs [*3] |-> rts_out)
		else $error("ready line low with handshake off");

	cover property (host_valid && host_ready && host_byte.last);
	cover property (rvalid && rready && rresp == `RESP_SLVERR);
	cover property (hs && rd_go);
	cover property (hs && !rts_out);
endmodule

// File: rx_term_pkg.sv
// Purpose: Types shared by the receive terminator modules.
// Assumes: Constants come from the header.
// Notes:   Types only.
`include "rx_term_consts.svh"

package rx_term_pkg;

	typedef struct packed {
		logic [7:0]       select;
		logic [2:0]       term_count;
		logic [5:0][7:0]  term_chars;
		logic [12:0]      packet_len;
		logic [15:0]      msg_ms;
		logic [15:0]      gap_ms;
		logic             handshake;
	} cfg_s;

	typedef struct packed {
		logic [7:0]  data;
		logic        last;
	} host_byte_s;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} wr_state_e;

endpackage

// File: serial_dev.sv
// Purpose: Serial field device that hands characters to the receiver.
// Assumes: send is called just after a rising edge.
// Notes:   Holds each character until it is taken.
module serial_dev (
	input  wire logic aclk,
	input  wire logic rx_ready,
	output logic      rx_valid,
	output logic [7:0] rx_char
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		rx_valid = 1'b0;
		rx_char = 8'h5A;
	end

	// Offers a character until taken, then lets the line change.
	task automatic send(input logic [7:0] c);
		logic t;
		rx_valid <= 1'b1;
		rx_char <= c;
		do begin
			@(negedge aclk);
			t = rx_ready;
			@(posedge aclk);
		end while (!t);
		rx_valid <= 1'b0;
		rx_char <= ~c;
		@(posedge aclk);
	endtask
endmodule

// File: serial_rx_message_terminator.sv
// Purpose: Collect received characters and hand them out as blocks.
// Assumes: rx_valid/rx_char come from a receiver on aclk; cts_in is a pin.
// Notes:   Registers over AXI4-Lite; blocks leave on the host byte port.
//
// Overview of operation
// - Selector bits: terminator, message, gap, length
// - Selector zero forwards each character immediately
// - Any enabled condition forwards the buffered data
// - Characters collect in a 4096-byte buffer
// - Terminator match forwards data including terminator
// - Message timer starts on first character
// - Gap timer restarts on every character
// - Forward each time length limit is reached
// - Full buffer forwards data automatically
// - Split oversized blocks into host-sized pages
// - Handshake setting drives and watches modem lines
// - Compare only the first count terminator slots
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`include "rx_term_consts.svh"

module serial_rx_message_terminator
	import rx_term_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES,
	parameter int DEPTH     = `BUF_DEPTH,
	parameter int PAGE_MAX  = `PAGE_MAX
) (
	// Clock and reset.
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// AXI4-Lite write address.
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [`AXI_ADDR_W-1:0] awaddr,
	// AXI4-Lite write data.
	input  wire logic                   wvalid,
	output logic                        wready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	// AXI4-Lite write response.
	output logic                        bvalid,
	input  wire logic                   bready,
	output logic [1:0]                  bresp,
	// AXI4-Lite read address.
	input  wire logic                   arvalid,
	output logic                        arready,
	input  wire logic [`AXI_ADDR_W-1:0] araddr,
	// AXI4-Lite read data.
	output logic                        rvalid,
	input  wire logic                   rready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	// Received characters.
	input  wire logic                   rx_valid,
	input  wire logic [7:0]             rx_char,
	output logic                        rx_ready,
	// Blocks toward the host.
	output logic                        host_valid,
	input  wire logic                   host_ready,
	output host_byte_s                  host_byte,
	// Modem control lines.
	input  wire logic                   cts_in,
	output logic                        rts_out
);

	localparam int CNT_W = $clog2(DEPTH) + 1;
	localparam int PTR_W = $clog2(DEPTH);

	////////////////////////////////////////////////////////////////////////
	// Helper functions.

	function automatic logic [31:0] reg_mask(input logic [3:0] idx);
		case (idx)
			4'h0:    reg_mask = `MASK_SELECT;
			4'h1:    reg_mask = `MASK_TERM_COUNT;
			4'h2:    reg_mask = `MASK_TERM_LO;
			4'h3:    reg_mask = `MASK_TERM_HI;
			4'h4:    reg_mask = `MASK_PKT_LEN;
			4'h5:    reg_mask = `MASK_MS;
			4'h6:    reg_mask = `MASK_MS;
			4'h7:    reg_mask = `MASK_HANDSHAKE;
			default: reg_mask = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic [31:0] reg_reset(input logic [3:0] idx);
		case (idx)
			4'h5:    reg_reset = `RESET_MSG_MS;
			4'h6:    reg_reset = `RESET_GAP_MS;
			default: reg_reset = `RESET_ZERO;
		endcase
	endfunction

	function automatic logic [31:0] apply_strb(input logic [31:0] old,
	                                           input logic [31:0] data,
	                                           input logic [3:0]  strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		apply_strb = res;
	endfunction

	function automatic logic term_match(input cfg_s c, input logic [7:0] ch);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < `TERM_SLOTS; i++) begin
			if ((3'(i) < c.term_count) && (c.term_chars[i] == ch)) begin
				hit = 1'b1;
			end
		end
		term_match = hit;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Configuration registers.

	logic [31:0]            regs [0:`NUM_CFG_REGS-1];
	cfg_s                   cfg;
	wr_state_e              wr_state;
	logic                   aw_held;
	logic                   w_held;
	logic [`AXI_ADDR_W-1:0] aw_addr_q;
	logic [31:0]            wdata_q;
	logic [3:0]             wstrb_q;

	assign cfg.select     = regs[0][7:0];
	assign cfg.term_count = regs[1][2:0];
	assign cfg.term_chars = {regs[3][15:0], regs[2]};
	assign cfg.packet_len = regs[4][12:0];
	assign cfg.msg_ms     = regs[5][15:0];
	assign cfg.gap_ms     = regs[6][15:0];
	assign cfg.handshake  = regs[7][0];

	wire        aw_take  = awvalid && awready;
	wire        w_take   = wvalid && wready;
	wire        do_write = aw_held && w_held && (wr_state == WR_IDLE);
	wire [3:0]  wr_idx   = aw_addr_q[5:2];
	wire        wr_ok    = (aw_addr_q[1:0] == 2'b00) &&
	                       (aw_addr_q < `ADDR_STATUS);
	wire        b_done   = bvalid && bready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `NUM_CFG_REGS; i++) begin
				regs[i] <= reg_reset(4'(i));
			end
		end else if (do_write && wr_ok) begin
			regs[wr_idx[2:0]] <= apply_strb(regs[wr_idx[2:0]], wdata_q,
			                                wstrb_q) & reg_mask(wr_idx);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			aw_addr_q <= '0;
			awready   <= 1'b1;
		end else if (aw_take) begin
			aw_held   <= 1'b1;
			aw_addr_q <= awaddr;
			awready   <= 1'b0;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end else if (b_done) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held  <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			wready  <= 1'b1;
		end else if (w_take) begin
			w_held  <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
			wready  <= 1'b0;
		end else if (do_write) begin
			w_held <= 1'b0;
		end else if (b_done) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state <= WR_IDLE;
			bvalid   <= 1'b0;
			bresp    <= `RESP_OKAY;
		end else begin
			case (wr_state)
				WR_IDLE: begin
					if (do_write) begin
						wr_state <= WR_RESP;
						bvalid   <= 1'b1;
						bresp    <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
					end
				end
				WR_RESP: begin
					if (bready) begin
						wr_state <= WR_IDLE;
						bvalid   <= 1'b0;
					end
				end
				default: begin
					wr_state <= WR_IDLE;
					bvalid   <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive buffer and block release.

	logic [7:0]       mem [0:DEPTH-1];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] pending;
	logic [CNT_W-1:0] avail;
	logic [CNT_W-1:0] occupancy;
	logic [15:0]      page_cnt;
	logic             cts_meta;
	logic             cts_sync;
	logic             msg_expired;
	logic             gap_expired;

	wire              wr_en    = rx_valid && rx_ready;
	wire [3:0]        sel      = cfg.select[3:0];
	wire [CNT_W-1:0]  pend_n   = pending + CNT_W'(wr_en);
	wire              stream   = (sel == 4'h0) && wr_en;
	wire              term_hit = sel[`SEL_TERM_BIT] && wr_en &&
	                             term_match(cfg, rx_char);
	wire              len_hit  = sel[`SEL_LEN_BIT] && wr_en &&
	                             (cfg.packet_len != 13'h0000) &&
	                             (pend_n >= CNT_W'(cfg.packet_len));
	wire              full_hit = wr_en &&
	                             (occupancy == CNT_W'(DEPTH - 1));
	wire              tmo_hit  = (pend_n != '0) &&
	                             ((sel[`SEL_MSG_BIT] && msg_expired) ||
	                              (sel[`SEL_GAP_BIT] && gap_expired));
	wire              release_blk = stream || term_hit || len_hit ||
	                                full_hit || tmo_hit;
	wire              load     = (avail != '0) && (!host_valid || host_ready);
	wire              page_end = (page_cnt == 16'(PAGE_MAX - 1));
	wire              msg_start = sel[`SEL_MSG_BIT] && wr_en &&
	                              (pending == '0);
	wire              gap_start = sel[`SEL_GAP_BIT] && wr_en;

	wire [CNT_W-1:0]  next_avail = avail - CNT_W'(load) +
	                               (release_blk ? pend_n : '0);
	wire [CNT_W-1:0]  next_occ   = occupancy + CNT_W'(wr_en) -
	                               CNT_W'(load);

	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_ptr] <= rx_char;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			pending   <= '0;
			avail     <= '0;
			occupancy <= '0;
			rx_ready  <= 1'b0;
		end else begin
			wr_ptr    <= wr_ptr + PTR_W'(wr_en);
			rd_ptr    <= rd_ptr + PTR_W'(load);
			pending   <= release_blk ? '0 : pend_n;
			avail     <= next_avail;
			occupancy <= next_occ;
			rx_ready  <= (next_occ < CNT_W'(DEPTH));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_valid <= 1'b0;
			host_byte  <= '0;
			page_cnt   <= 16'h0000;
		end else if (load) begin
			host_valid     <= 1'b1;
			host_byte.data <= mem[rd_ptr];
			host_byte.last <= (avail == CNT_W'(1)) || page_end;
			page_cnt       <= (avail == CNT_W'(1)) || page_end ?
			                  16'h0000 : page_cnt + 16'h0001;
		end else if (host_ready) begin
			host_valid <= 1'b0;
		end
	end

	ms_timer #(
		.MS_CYCLES (MS_CYCLES)
	) msg_timer (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.clear     (release_blk),
		.start     (msg_start),
		.period_ms (cfg.msg_ms),
		.expired   (msg_expired)
	);

	ms_timer #(
		.MS_CYCLES (MS_CYCLES)
	) gap_timer (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.clear     (release_blk),
		.start     (gap_start),
		.period_ms (cfg.gap_ms),
		.expired   (gap_expired)
	);

	////////////////////////////////////////////////////////////////////////
	// Modem control lines.

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cts_meta <= 1'b0;
			cts_sync <= 1'b0;
			rts_out  <= 1'b1;
		end else begin
			cts_meta <= cts_in;
			cts_sync <= cts_meta;
			rts_out  <= !cfg.handshake ||
			            (next_occ < CNT_W'(DEPTH - `RTS_MARGIN));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register reads.

	wire [3:0]  rd_idx = araddr[5:2];
	wire        rd_ok  = (araddr[1:0] == 2'b00) && (araddr <= `ADDR_LEVELS);
	wire        ar_take = arvalid && arready;
	wire [31:0] status_word = {cfg.handshake && cts_sync, rts_out, 1'b0,
	                           occupancy, 3'b000, pending};
	wire [31:0] levels_word = {19'h00000, avail};
	wire [31:0] rd_word = (araddr == `ADDR_STATUS) ? status_word :
	                      (araddr == `ADDR_LEVELS) ? levels_word :
	                      (rd_idx < 4'(`NUM_CFG_REGS)) ?
	                      regs[rd_idx[2:0]] : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_ok ? rd_word : 32'h0000_0000;
			rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

endmodule

// File: tb_serial_rx_message_terminator.sv
// Purpose: Self-checking bench for the receive terminator.
// Assumes: Short millisecond count; read answers are taken after a random wait.
// Notes:   Drivers note results in queues; one watcher compares them.
`include "rx_term_consts.svh"
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

module tb_serial_rx_message_terminator
	import rx_term_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSC = 10;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b1, arvalid = 1'b0, rready = 1'b1, cts_in = 1'b0;
	logic host_ready = 1'b0, stall = 1'b0;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp, e2;
	logic awready, wready, bvalid, arready, rvalid, rx_ready;
	logic host_valid, rts_out, rx_valid;
	logic [7:0] rx_char;
	logic [9:0] e10;
	logic [33:0] e34;
	logic [15:0] lf = 16'hE469;
	host_byte_s host_byte;
	logic [1:0] bq[$];
	logic [9:0] hq[$];
	logic [33:0] rq[$];
	int error_cnt = 0;
	int checks = 0;

	serial_rx_message_terminator #(.MS_CYCLES(MSC)) i_dut (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp, .rx_valid, .rx_char,
		.rx_ready, .host_valid, .host_ready, .host_byte, .cts_in, .rts_out
	);
	serial_dev i_dev (.aclk, .rx_ready, .rx_valid, .rx_char);

	always #2.5 aclk = ~aclk;

	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Host takes bytes, stalling on random cycles when asked.
	always @(posedge aclk) begin
		lf <= nx(lf);
		host_ready <= aresetn && (!stall || lf[0]);
	end

	////////////////////////////////////////
	always @(negedge aclk) begin
		if (bvalid && bready) begin
			e2 = bq.pop_front();
			`CMP(bresp, e2)
		end
		if (rvalid && rready) begin
			e34 = rq.pop_front();
			`CMP({rresp, rdata}, e34)
		end
		if (host_valid && host_ready) begin
			e10 = hq.pop_front();
			`CMP(host_byte.data, e10[8:1])
			if (e10[9])
				`CMP(host_byte.last, e10[0])
		end
	end

	task automatic wr(input logic [5:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic da, dw, ta, tw;
		bq.push_back(r);
		da = 1'b0;
		dw = 1'b0;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		while (!(da && dw)) begin
			@(negedge aclk);
			ta = awready && !da;
			tw = wready && !dw;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			da = da || ta;
			dw = dw || tw;
		end
		do begin
			@(negedge aclk);
			ta = bvalid;
			@(posedge aclk);
		end while (!ta);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic t;
		rq.push_back({r, d});
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b0;
		do begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end while (!t);
		arvalid <= 1'b0;
		if (lf[1])
			@(posedge aclk);
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			t = rvalid;
			@(posedge aclk);
		end while (!t);
	endtask

	task automatic snd(input logic [7:0] c, input logic l, input logic k);
		hq.push_back({k, c, l});
		i_dev.send(c);
	endtask

	task automatic msg(input string s, input int g, input logic l);
		for (int i = 0; i < s.len(); i++) begin
			snd(s[i], l && i == s.len() - 1, 1'b1);
			repeat (g) @(posedge aclk);
		end
		if (l)
			drain();
	endtask

	task automatic drain;
		for (int i = 0; i < 9000 && hq.size() > 0; i++)
			@(posedge aclk);
	endtask

	task automatic fin(input string n);
		drain();
		`CMP(hq.size(), 0)
		$display("test %s done", n);
	endtask

	task summarize;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#200000;
		error_cnt++;
		summarize();
	end

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`ADDR_SELECT, `RESET_ZERO, `RESP_OKAY);
		rd(`ADDR_MSG_MS, `RESET_MSG_MS, `RESP_OKAY);
		rd(`ADDR_GAP_MS, `RESET_GAP_MS, `RESP_OKAY);
		rd(6'h28, `RESET_ZERO, `RESP_SLVERR);
		wr(6'h02, 32'h0000_00FF, `RESP_SLVERR);
		rd(`ADDR_SELECT, `RESET_ZERO, `RESP_OKAY);
		for (int i = 0; i < 4; i++)
			snd(8'h30 + 8'(i), 1'b1, 1'b1);
		stall <= 1'b1;
		for (int i = 0; i < 16; i++)
			snd(lf[15:8], 1'b1, 1'b0);
		fin("stream");
		stall <= 1'b0;
		wr(`ADDR_SELECT, 32'h0000_00F1, `RESP_OKAY);
		rd(`ADDR_SELECT, 32'h0000_00F1, `RESP_OKAY);
		wr(`ADDR_TERM_COUNT, 32'h0000_0002, `RESP_OKAY);
		wr(`ADDR_TERM_LO, 32'h005A_0A0D, `RESP_OKAY);
		msg("ABZC\n", 0, 1'b1);
		msg("D\r", 0, 1'b1);
		fin("term");
		wr(`ADDR_SELECT, 32'h0000_0009, `RESP_OKAY);
		wr(`ADDR_PKT_LEN, 32'h0000_0003, `RESP_OKAY);
		msg("A\r", 0, 1'b1);
		msg("BCD", 0, 1'b1);
		fin("any");
		wr(`ADDR_SELECT, 32'h0000_0008, `RESP_OKAY);
		wr(`ADDR_PKT_LEN, 32'h0000_0004, `RESP_OKAY);
		msg("ABCD", 0, 1'b1);
		msg("EFGH", 0, 1'b1);
		msg("IJ", 0, 1'b0);
		repeat (10) @(posedge aclk);
		rd(`ADDR_STATUS, 32'h4002_0002, `RESP_OKAY);
		rd(`ADDR_LEVELS, `RESET_ZERO, `RESP_OKAY);
		msg("KL", 0, 1'b1);
		fin("len");
		wr(`ADDR_SELECT, 32'h0000_0002, `RESP_OKAY);
		wr(`ADDR_MSG_MS, 32'h0000_0003, `RESP_OKAY);
		msg("ABCDE", 3, 1'b1);
		repeat (20) @(posedge aclk);
		msg("FG", 3, 1'b1);
		fin("message");
		wr(`ADDR_SELECT, 32'h0000_0004, `RESP_OKAY);
		wr(`ADDR_GAP_MS, 32'h0000_0002, `RESP_OKAY);
		msg("ABCDEF", 5, 1'b1);
		repeat (30) @(posedge aclk);
		msg("GH", 5, 1'b1);
		fin("gap");
		wr(`ADDR_SELECT, 32'h0000_0008, `RESP_OKAY);
		wr(`ADDR_PKT_LEN, 32'h0000_0000, `RESP_OKAY);
		wr(`ADDR_HANDSHAKE, 32'h0000_0001, `RESP_OKAY);
		for (int i = 0; i < `BUF_DEPTH; i++)
			snd(lf[7:0], i % `PAGE_MAX == `PAGE_MAX - 1 ||
				i == `BUF_DEPTH - 1, 1'b1);
		fin("full");
		for (int i = 0; i < 3; i++) begin
			wr(`ADDR_HANDSHAKE, {31'h0, i < 2}, `RESP_OKAY);
			cts_in <= i != 0;
			repeat (4) @(posedge aclk);
			rd(`ADDR_STATUS, {i == 1, 1'b1, 30'h0}, `RESP_OKAY);
		end
		fin("handshake");
		summarize();
	end
endmodule

bind serial_rx_message_terminator rx_term_monitor i_mon (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
	.arvalid, .arready, .rvalid, .rready, .awaddr, .araddr, .wdata, .rdata,
	.rresp, .rx_valid, .rx_ready, .host_valid, .host_ready, .rts_out,
	.rx_char, .host_byte
);
